// ==== include/nvm_bridge_cfg.svh ====
// Function
// (R1) Store accessed only in whole 16-byte pages
// (R2) Store has configuration, user and feature sectors
// (R3) Priority: JTAG, slave SPI, I2C, then bus
// (R4) Transparent enable suspends power, reset, SPI, I2C
// (R5) Disable then bypass restores suspended features
// (R6) Host sets connection enable around each command
// (R7) FIFO reset bit holds FIFOs while set
// (R8) Transmit write sends byte to configuration logic
// (R9) Receive register shows byte from configuration logic
// (R10) Status bit 7 shows connection active
// (R11) Status bits 5..2 show FIFO states
// (R12) Status bit 1: slave SPI preempts bridge
// (R13) Status bit 0: I2C port preempts bridge
// (R14) Enabled flags latch, host clears by writing 1
// (R15) Enable register gates each source
// (R16) Host writes reserved bits as zero
// (R17) Source register ORs each block's status
// (R18) Host sends all bytes through transmit register
// (R19) Host disables interface only when not busy
// (R20) Bridge raises request when any status set
`ifndef NVM_BRIDGE_CFG_SVH
`define NVM_BRIDGE_CFG_SVH
// ====================
// Register offsets
`define REG_CONTROL      8'h70
`define REG_TX_BYTE      8'h71
`define REG_STATUS       8'h72
`define REG_RX_BYTE      8'h73
`define REG_IRQ_STATUS   8'h74
`define REG_IRQ_ENABLE   8'h75
`define REG_UNUSED       8'h76
`define REG_IRQ_SOURCE   8'h77
// ====================
// Field positions
`define BIT_CONN_ENABLE  7
`define BIT_FIFO_RESET   6
`define BIT_CONN_ACTIVE  7
`define BIT_SRC_BRIDGE   4
`define IRQ_MSB          5
// ====================
// Reset values, sizes and command bytes
`define RESET_BYTE       8'h00
`define PAGE_BYTES       16
`define CMD_ENABLE_X     8'h74
`define CMD_DISABLE      8'h26
`define CMD_BYPASS       8'hff
`endif

// ==== include/nvm_bridge_pkg.sv ====
package nvm_bridge_pkg;
  // Flags of the bridge, in status bit order 5..0
  typedef struct packed {
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;
    logic slave_spi_busy_flag;
    logic i2c_port_busy_flag;
  } flags_t;
  // Ports competing for the store, highest first
  typedef struct packed {
    logic jtag;
    logic slave_spi;
    logic i2c;
  } ports_t;
  // Suspend tracking of transparent mode
  typedef enum logic [1:0] {
    SUS_IDLE    = 2'b00,
    SUS_ACTIVE  = 2'b01,
    SUS_CLOSING = 2'b11
  } sus_state_t;
endpackage

// ==== src/nvm_byte_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvm_byte_fifo #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  // Fill side
  input  wire logic       wr_valid_i,
  input  wire logic [7:0] wr_data_i,
  output logic            wr_ready_o,
  // Drain side
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o,
  input  wire logic       rd_ready_i,
  // Levels
  output logic            empty_o,
  output logic            full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire do_wr = wr_valid_i && !full_o;
  wire do_rd = rd_ready_i && !empty_o;
  // Levels from pointer compare
  assign empty_o    = (wp_r == rp_r);
  assign full_o     = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign wr_ready_o = !full_o;
  assign rd_valid_o = !empty_o;
  assign rd_data_o  = mem[rp_r[AW-1:0]];
  // Storage
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) mem[wp_r[AW-1:0]] <= wr_data_i;
  end
  // Pointers, cleared while held in reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (clear_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== src/nvm_port_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module nvm_port_arbiter (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  // Competing ports
  input  wire nvm_bridge_pkg::ports_t req_i,
  input  wire logic                   bridge_req_i,
  // Grant to bridge and preemption flags
  output logic                        bridge_grant_o,
  output logic                        spi_preempt_o,
  output logic                        i2c_preempt_o
);
  // Fixed priority, higher ports block lower
  wire grant_nxt = bridge_req_i && !req_i.jtag && !req_i.slave_spi && !req_i.i2c; // R3
  wire spi_nxt   = bridge_req_i && !req_i.jtag && req_i.slave_spi;                // R12
  wire i2c_nxt   = bridge_req_i && !req_i.jtag && !req_i.slave_spi && req_i.i2c;  // R13
  // Registered grant
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bridge_grant_o <= 1'b0;
      spi_preempt_o  <= 1'b0;
      i2c_preempt_o  <= 1'b0;
    end else begin
      bridge_grant_o <= grant_nxt;
      spi_preempt_o  <= spi_nxt;
      i2c_preempt_o  <= i2c_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== src/nvm_config_bus_bridge.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nvm_bridge_cfg.svh"
module nvm_config_bus_bridge #(
  parameter int FIFO_DEPTH = `PAGE_BYTES                         // R1
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  // Byte-wide bus slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [7:0]             wb_dat_i,
  output logic [7:0]                  wb_dat_o,
  output logic                        wb_ack_o,
  // Competing ports
  input  wire nvm_bridge_pkg::ports_t port_req_i,
  // Configuration logic byte streams
  output logic                        cfg_tx_valid_o,
  output logic [7:0]                  cfg_tx_data_o,
  input  wire logic                   cfg_tx_ready_i,
  input  wire logic                   cfg_rx_valid_i,
  input  wire logic [7:0]             cfg_rx_data_i,
  output logic                        cfg_rx_ready_o,
  output logic                        cfg_frame_o,
  // Other embedded blocks' interrupt levels
  input  wire logic                   timer_source_i,
  input  wire logic                   spi_source_i,
  input  wire logic                   secondary_i2c_source_i,
  input  wire logic                   primary_i2c_source_i,
  // Interrupt request and suspend of features
  output logic                        irq_o,
  output logic                        suspend_o
);
  // ====================
  // Registers
  logic [7:0]             control_r;
  logic [7:0]             rx_byte_r;
  logic [`IRQ_MSB:0]      irq_status_r;
  logic [`IRQ_MSB:0]      irq_enable_r;
  logic [7:0]             rd_data_r;
  logic                   ack_r;
  logic                   tx_push_r;
  logic [7:0]             tx_hold_r;
  logic [2:0]             cmd_pos_r;
  logic [7:0]             cmd_byte_r;
  nvm_bridge_pkg::sus_state_t sus_r;
  nvm_bridge_pkg::sus_state_t sus_nxt;
  logic                   suspend_r;
  logic                   tx_fifo_valid;
  logic [7:0]             tx_fifo_data;
  logic                   tx_empty;
  logic                   tx_full;
  logic                   rx_empty;
  logic                   rx_full;
  logic                   rx_out_valid;
  logic [7:0]             rx_out_data;
  logic                   grant;
  logic                   spi_pre;
  logic                   i2c_pre;
  logic                   irq_r;
  nvm_bridge_pkg::flags_t flags;

  // ====================
  // Address decode
  wire access     = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_access  = access && wb_we_i;
  wire rd_access  = access && !wb_we_i;
  wire hit_ctrl   = (wb_adr_i == `REG_CONTROL);
  wire hit_tx     = (wb_adr_i == `REG_TX_BYTE);
  wire hit_rx     = (wb_adr_i == `REG_RX_BYTE);
  wire hit_irq    = (wb_adr_i == `REG_IRQ_STATUS);
  wire hit_en     = (wb_adr_i == `REG_IRQ_ENABLE);
  wire conn_en    = control_r[`BIT_CONN_ENABLE];
  wire fifo_clr   = control_r[`BIT_FIFO_RESET];                   // R7
  wire conn_act   = conn_en && grant;                             // R10
  wire rx_pop     = rd_access && hit_rx;

  // ====================
  // FIFOs and arbiter
  nvm_byte_fifo #(.DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (fifo_clr),                                       // R7
    .wr_valid_i (tx_push_r),                                      // R8
    .wr_data_i  (tx_hold_r),
    .wr_ready_o (),
    .rd_valid_o (tx_fifo_valid),
    .rd_data_o  (tx_fifo_data),
    .rd_ready_i (cfg_tx_ready_i && conn_act),
    .empty_o    (tx_empty),
    .full_o     (tx_full)
  );
  nvm_byte_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (fifo_clr),
    .wr_valid_i (cfg_rx_valid_i && conn_act),                     // R9
    .wr_data_i  (cfg_rx_data_i),
    .wr_ready_o (cfg_rx_ready_o),
    .rd_valid_o (rx_out_valid),
    .rd_data_o  (rx_out_data),
    .rd_ready_i (rx_pop),
    .empty_o    (rx_empty),
    .full_o     (rx_full)
  );
  nvm_port_arbiter u_arb (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .req_i          (port_req_i),
    .bridge_req_i   (conn_en),
    .bridge_grant_o (grant),
    .spi_preempt_o  (spi_pre),
    .i2c_preempt_o  (i2c_pre)
  );

  // ====================
  // Flags and interrupt sources
  assign flags.tx_empty            = tx_empty;                    // R11
  assign flags.tx_full             = tx_full;
  assign flags.rx_empty            = rx_empty;
  assign flags.rx_full             = rx_full;
  assign flags.slave_spi_busy_flag = spi_pre;                     // R12
  assign flags.i2c_port_busy_flag  = i2c_pre;                     // R13
  wire [`IRQ_MSB:0] flag_vec  = flags;
  wire [`IRQ_MSB:0] irq_set   = flag_vec & irq_enable_r;          // R15
  wire [`IRQ_MSB:0] irq_clr   = (wr_access && hit_irq) ? wb_dat_i[`IRQ_MSB:0] : '0;
  wire [`IRQ_MSB:0] irq_nxt   = irq_set | (irq_status_r & ~irq_clr); // R14
  wire              bridge_int = |irq_status_r;                   // R20
  wire [7:0] status_byte = {conn_act, 1'b0, flag_vec};            // R10
  wire [7:0] source_byte = {3'b000, bridge_int, timer_source_i, spi_source_i,
                            secondary_i2c_source_i, primary_i2c_source_i}; // R17

  // ====================
  // Read mux, unmapped and write-only read as zero
  wire [7:0] rd_mux =
    hit_ctrl ? control_r :
    (wb_adr_i == `REG_STATUS) ? status_byte :
    hit_rx ? (rx_out_valid ? rx_out_data : rx_byte_r) :
    hit_irq ? {2'b00, irq_status_r} :
    hit_en ? {2'b00, irq_enable_r} :
    (wb_adr_i == `REG_IRQ_SOURCE) ? source_byte : `RESET_BYTE;

  // ====================
  // Command tracking for transparent mode suspend
  wire tx_take = tx_fifo_valid && cfg_tx_ready_i && conn_act;
  wire cmd_first = tx_take && (cmd_pos_r == 3'd0);
  always_comb begin
    sus_nxt = sus_r;
    case (sus_r)
      nvm_bridge_pkg::SUS_IDLE:
        if (cmd_first && tx_fifo_data == `CMD_ENABLE_X) sus_nxt = nvm_bridge_pkg::SUS_ACTIVE; // R4
      nvm_bridge_pkg::SUS_ACTIVE:
        if (cmd_first && tx_fifo_data == `CMD_DISABLE) sus_nxt = nvm_bridge_pkg::SUS_CLOSING; // R5
      nvm_bridge_pkg::SUS_CLOSING:
        if (cmd_first) begin
          if (tx_fifo_data == `CMD_BYPASS) sus_nxt = nvm_bridge_pkg::SUS_IDLE;               // R5
          else sus_nxt = nvm_bridge_pkg::SUS_CLOSING;
        end
      default:
        sus_nxt = nvm_bridge_pkg::SUS_IDLE;
    endcase
  end

  // ====================
  // Bus registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_r    <= `RESET_BYTE;
      irq_enable_r <= '0;
      irq_status_r <= '0;
    end else begin
      if (wr_access && hit_ctrl)
        control_r <= {wb_dat_i[`BIT_CONN_ENABLE], wb_dat_i[`BIT_FIFO_RESET], 6'b000000};
      if (wr_access && hit_en) irq_enable_r <= wb_dat_i[`IRQ_MSB:0];
      irq_status_r <= irq_nxt;                                    // R14
    end
  end

  // Transmit write capture and bus answer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r     <= 1'b0;
      rd_data_r <= `RESET_BYTE;
      tx_push_r <= 1'b0;
      tx_hold_r <= `RESET_BYTE;
    end else begin
      ack_r     <= access;
      rd_data_r <= rd_access ? rd_mux : rd_data_r;
      tx_push_r <= wr_access && hit_tx && !fifo_clr;              // R8
      tx_hold_r <= (wr_access && hit_tx) ? wb_dat_i : tx_hold_r;
    end
  end

  // Last received byte, held for reads on empty
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rx_byte_r <= `RESET_BYTE;
    else if (rx_pop && rx_out_valid) rx_byte_r <= rx_out_data;    // R9
  end

  // Command framing: position restarts when enable drops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_pos_r  <= 3'd0;
      cmd_byte_r <= `RESET_BYTE;
    end else if (!conn_en) begin
      cmd_pos_r  <= 3'd0;                                         // R6
    end else if (tx_take) begin
      cmd_pos_r  <= (cmd_pos_r == 3'd7) ? cmd_pos_r : cmd_pos_r + 3'd1;
      cmd_byte_r <= cmd_first ? tx_fifo_data : cmd_byte_r;
    end
  end

  // Suspend state and outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sus_r     <= nvm_bridge_pkg::SUS_IDLE;
      suspend_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      sus_r     <= sus_nxt;
      suspend_r <= (sus_nxt != nvm_bridge_pkg::SUS_IDLE);         // R4
      irq_r     <= |irq_nxt;                                      // R20
    end
  end

  // ====================
  // Output drive
  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = rd_data_r;
  assign cfg_tx_valid_o = tx_fifo_valid && conn_act;
  assign cfg_tx_data_o  = tx_fifo_data;
  assign cfg_frame_o    = conn_act;
  assign irq_o          = irq_r;
  assign suspend_o      = suspend_r;
endmodule
`default_nettype wire

// ==== tb/nvm_bridge_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bus and stream checks
module nvm_bridge_monitor (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_ack_o,
  // Far side
  input wire nvm_bridge_pkg::ports_t port_req_i,
  input wire logic       cfg_tx_valid_o,
  input wire logic [7:0] cfg_tx_data_o,
  input wire logic       cfg_tx_ready_i,
  input wire logic       cfg_frame_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_req ##0 !wb_we_i && wb_adr_i == a;
  endsequence
  sequence s_jtag;
    port_req_i.jtag [*2];
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("no ack");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("stray ack");
  a_rsvd_reads_zero: assert property ((s_rd(8'h71) or s_rd(8'h76)) |=> wb_dat_o == 8'h00)
    else $error("reserved read");
  a_status_shows_active: assert property (s_rd(8'h72) |=>
    wb_dat_o[7:6] == {$past(cfg_frame_o), 1'b0}) else $error("status bit7");
  a_tx_needs_frame: assert property (cfg_tx_valid_o && cfg_tx_ready_i |-> cfg_frame_o)
    else $error("transfer outside frame");
  a_jtag_blocks_all: assert property (s_jtag |=> !cfg_frame_o) else $error("not blocked");
  a_tx_byte_holds: assert property (cfg_tx_valid_o && !cfg_tx_ready_i |=>
    cfg_tx_valid_o && $stable(cfg_tx_data_o)) else $error("byte dropped");
endmodule
bind nvm_config_bus_bridge nvm_bridge_monitor u_mon (.sys_clk_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .port_req_i, .cfg_tx_valid_o,
  .cfg_tx_data_o, .cfg_tx_ready_i, .cfg_frame_o);
`default_nettype wire

// ==== tb/cfg_logic_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// Configuration logic stand-in
module cfg_logic_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Byte streams
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output var logic        rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  input  wire logic       frame_i,
  // Slow answer
  input  wire logic       stall_i
);
  logic [7:0] got_q[$];
  logic [7:0] reply_r;
  // One byte at a time; idle data is the inverse of the last reply
  assign tx_ready_o = !stall_i && !rx_valid_o;
  assign rx_data_o  = rx_valid_o ? reply_r : ~reply_r;
  // Answer each byte with its inverse
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      reply_r    <= 8'h00;
    end else if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_data_i);
      rx_valid_o <= 1'b1;
      reply_r    <= ~tx_data_i;
    end else if (rx_valid_o && rx_ready_i && frame_i) begin
      rx_valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench top
module tb_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cyc = 1'b0;
  logic       stb = 1'b0;
  logic       we = 1'b0;
  logic       stall = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [3:0] src = 4'h0;
  logic [7:0] rdat, txd, rxd, q;
  logic       ack, txv, txr, rxv, rxr, frame, irq, susp;
  int         failures = 0;
  int         compares = 0;
  nvm_bridge_pkg::ports_t req = '0;

  // Clock
  always #4 clk = ~clk;

  nvm_config_bus_bridge #(.FIFO_DEPTH(16)) uut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_req_i(req), .cfg_tx_valid_o(txv),
    .cfg_tx_data_o(txd), .cfg_tx_ready_i(txr), .cfg_rx_valid_i(rxv), .cfg_rx_data_i(rxd),
    .cfg_rx_ready_o(rxr), .cfg_frame_o(frame), .timer_source_i(src[3]),
    .spi_source_i(src[2]), .secondary_i2c_source_i(src[1]),
    .primary_i2c_source_i(src[0]), .irq_o(irq), .suspend_o(susp));

  cfg_logic_model pm (.sys_clk_i(clk), .rst_n_i(rst_n), .tx_valid_i(txv), .tx_data_i(txd),
    .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rxr),
    .frame_i(frame), .stall_i(stall));

  // ====================
  // Shared tasks
  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask

  // ====================
  // Scenarios
  task automatic t_reset;
    logic [7:0] e [8];
    e = '{8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rd(8'h70 + i[7:0], 8'hff, e[i]);
  endtask
  task automatic t_irq;
    bus(1'b1, 8'h75, 8'h20);
    rd(8'h75, 8'hff, 8'h20);
    rd(8'h74, 8'hff, 8'h20);
    chk({7'h00, irq}, 8'h01);
    rd(8'h77, 8'h10, 8'h10);
    bus(1'b1, 8'h74, 8'h20);
    rd(8'h74, 8'hff, 8'h20);
    bus(1'b1, 8'h75, 8'h00);
    bus(1'b1, 8'h74, 8'h3f);
    rd(8'h74, 8'hff, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(8'h77, 8'h10, 8'h00);
  endtask
  // Enable, disable, bypass; first byte held back by a slow far side
  task automatic t_cmds;
    logic [7:0] c [3];
    logic       s [3];
    c = '{8'h74, 8'h26, 8'hff};
    s = '{1'b1, 1'b1, 1'b0};
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h70, 8'h80);
      bus(1'b1, 8'h71, c[i]);
      repeat (8) @(posedge clk);
      rd(8'h72, 8'ha0, {2'b10, (i != 0), 5'h00});
      stall <= 1'b0;
      repeat (8) @(posedge clk);
      bus(1'b1, 8'h70, 8'h00);
      chk({7'h00, susp}, {7'h00, s[i]});
      chk(pm.got_q[i], c[i]);
      rd(8'h73, 8'hff, ~c[i]);
    end
  endtask
  // Fill while disconnected, then flush
  task automatic t_fill;
    for (int i = 0; i < 16; i++) bus(1'b1, 8'h71, i[7:0]);
    rd(8'h72, 8'hb0, 8'h10);
    bus(1'b1, 8'h70, 8'h40);
    bus(1'b1, 8'h71, 8'h5a);
    rd(8'h70, 8'hff, 8'h40);
    rd(8'h72, 8'h30, 8'h20);
    bus(1'b1, 8'h70, 8'h00);
    rd(8'h72, 8'h30, 8'h20);
  endtask
  task automatic t_preempt;
    logic [2:0] p [4];
    logic [7:0] e [4];
    p = '{3'b010, 3'b001, 3'b100, 3'b000};
    e = '{8'h02, 8'h01, 8'h00, 8'h80};
    bus(1'b1, 8'h70, 8'h80);
    for (int i = 0; i < 4; i++) begin
      req <= p[i];
      repeat (4) @(posedge clk);
      rd(8'h72, 8'h83, e[i]);
    end
    bus(1'b1, 8'h70, 8'h00);
  endtask
  task automatic t_sources;
    for (int i = 0; i < 4; i++) begin
      src <= 4'h1 << i;
      rd(8'h77, 8'h0f, 8'h01 << i);
    end
    src <= 4'h0;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_irq;
    t_cmds;
    t_fill;
    t_preempt;
    t_sources;
    complete_run;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
